// ===== include/cpiu_defines.vh
// Offsets, field positions, reset values and timing for the interrupt unit.
`ifndef CPIU_DEFINES_VH
`define CPIU_DEFINES_VH

// ---------------------------------------------------------------
// Address width and register offsets
// ---------------------------------------------------------------
`define CPIU_ADDR_W        12
`define CPIU_OFS_CTRL      12'h00B
`define CPIU_OFS_FLAG_A    12'h011
`define CPIU_OFS_FLAG_B    12'h012
`define CPIU_OFS_EN_A      12'h091
`define CPIU_OFS_EN_B      12'h092
`define CPIU_OFS_EDGE      12'h095
`define CPIU_OFS_PCF       12'h396
`define CPIU_OFS_SHD_STAT  12'hFE4
`define CPIU_OFS_SHD_ACC   12'hFE5
`define CPIU_OFS_SHD_BSR   12'hFE6
`define CPIU_OFS_SHD_PCLH  12'hFE7
`define CPIU_OFS_SHD_F0L   12'hFE8
`define CPIU_OFS_SHD_F0H   12'hFE9
`define CPIU_OFS_SHD_F1L   12'hFEA
`define CPIU_OFS_SHD_F1H   12'hFEB

// ---------------------------------------------------------------
// Control and edge register fields
// ---------------------------------------------------------------
`define CPIU_CTL_GIE       7
`define CPIU_CTL_PERIPHERAL_IRQ_ENABLE      6
`define CPIU_CTL_TMR_EN    5
`define CPIU_CTL_EXT_EN    4
`define CPIU_CTL_CHG_EN    3
`define CPIU_CTL_TMR_FLG   2
`define CPIU_CTL_EXT_FLG   1
`define CPIU_CTL_CHG_FLG   0
`define CPIU_EDGE_SEL      0

// Status bits that are saved; watchdog expired and sleep entered never are.
`define CPIU_STAT_KEEP     8'hE7

// ---------------------------------------------------------------
// Reset values, vector address and timing
// ---------------------------------------------------------------
`define CPIU_RST_BYTE      8'h00
`define CPIU_VECTOR        15'h0004
`define CPIU_PHASES        4
`define CPIU_PHASE_Q1      2'h0
`define CPIU_PHASE_Q4      2'h3
`define CPIU_WAKE_HOLD     2'h2

`endif

// ===== verilog/cpiu_irq_unit.v
// Interrupt unit of the core: flags, enables, vectoring, context shadows.
//
// Function
// - Reset leaves every interrupt disabled.
// - Take only with global, own, group enables.
// - Flags set regardless of any enable.
// - Entry flushes, clears global, pushes, saves, vectors.
// - Global clear only records; service when set.
// - Return pops, restores context, sets global.
// - Flag left set re-enters after return.
// - Synchronous latency three or four cycles.
// - Asynchronous latency three to five cycles.
// - Latency independent of instruction length.
// - Pin flag sampled in first phase.
// - Pin flag may set fourth-first phase.
// - Wake vectors if global set, else continues.
// - Instruction after sleep runs before vectoring.
// - Pin edge-triggered, edge chosen by select.
// - Valid edge sets flag; vector needs enables.
// - Entry copies accumulator, bank, pointers, latch, status.
// - Return restores shadows; shadow edits take effect.
// - Shadows software readable, writable, in top bank.
// - Change summary read-only, clears with flags.
//
// Strobed register access and the placing of the registers are this design's own decisions.

`include "cpiu_defines.vh"

module cpiu_irq_unit #(
  parameter PC_W = 15                   // Program counter width.
) (
  input  wire             clk_i,        // Instruction clock, 125 MHz.
  input  wire             rst_n_i,      // Asynchronous reset, active low.
  input  wire [11:0]      addr_i,       // Register address.
  input  wire [7:0]       wdata_i,      // Register write data.
  input  wire             wr_i,         // Write strobe.
  input  wire             rd_i,         // Read strobe.
  output reg  [7:0]       rdata_o,      // Read data, cycle after rd_i.
  input  wire             tmr_evt_i,    // Timer overflow event pulse.
  input  wire [7:0]       evt_a_i,      // Peripheral group A events.
  input  wire [7:0]       evt_b_i,      // Peripheral group B events.
  input  wire [7:0]       chg_evt_i,    // Pin change events.
  input  wire             ext_pin_i,    // External interrupt pin level.
  input  wire [PC_W-1:0]  pc_i,         // Current program counter.
  input  wire [7:0]       live_acc_i,   // Live accumulator.
  input  wire [7:0]       live_stat_i,  // Live status register.
  input  wire [4:0]       live_bsr_i,   // Live bank select register.
  input  wire [15:0]      live_fsr0_i,  // Live file select pointer 0.
  input  wire [15:0]      live_fsr1_i,  // Live file select pointer 1.
  input  wire [6:0]       live_pclh_i,  // Live program counter high latch.
  input  wire             return_from_isr_instr_i,     // Return-from-service pulse.
  input  wire             sleep_i,      // Core is asleep, level.
  output reg  [1:0]       phase_o,      // Current phase, 0 means Q1.
  output reg              irq_req_o,    // Enabled request pending.
  output reg              flush_o,      // Flush prefetched instruction.
  output reg              push_o,       // Push return address.
  output reg  [PC_W-1:0]  push_pc_o,    // Address to push.
  output reg              pc_load_o,    // Load the program counter.
  output reg  [PC_W-1:0]  pc_val_o,     // Value to load, the vector.
  output reg              pop_o,        // Pop return address.
  output reg              restore_o,    // Restore context from shadows.
  output reg              wake_o,       // Wake request to the core.
  output reg  [7:0]       shd_acc_o,    // Shadow accumulator.
  output reg  [7:0]       shd_stat_o,   // Shadow status register.
  output reg  [4:0]       shd_bsr_o,    // Shadow bank select register.
  output reg  [15:0]      shd_fsr0_o,   // Shadow file select pointer 0.
  output reg  [15:0]      shd_fsr1_o,   // Shadow file select pointer 1.
  output reg  [6:0]       shd_pclh_o    // Shadow program counter latch.
);

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;     // Normal execution.
  localparam [1:0] ST_FLUSH = 2'h1;     // First forced no-op cycle.
  localparam [1:0] ST_VEC   = 2'h2;     // Second no-op, vector loaded.

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg [7:0] ctrl;                       // Control: enables and flags.
  reg [7:0] pflag [0:1];                // Peripheral flag registers.
  reg [7:0] pen   [0:1];                // Peripheral enable registers.
  reg       edge_sel;                   // One selects rising edge.
  reg [7:0] chg_flag;                   // Port change flag register.
  reg       pin_prev;                   // Pin level one cycle ago.
  reg       pin_seen;                   // Pin history is valid.
  reg [1:0] state;                      // Entry sequencer state.
  reg [1:0] hold;                       // Cycles blocked after wake.

  wire [7:0] evt [0:1];                 // Group events by index.
  wire       is_q1;                     // This edge opens a cycle.
  wire       pin_edge;                  // Selected pin edge seen.
  wire       chg_sum;                   // Pin change summary flag.
  wire       any_en;                    // Any enabled flag set.
  wire       take;                      // Start entry this edge.
  wire       wr_ctrl;                   // Write to control register.

  assign evt[0] = evt_a_i;
  assign evt[1] = evt_b_i;
  assign is_q1  = (phase_o == `CPIU_PHASE_Q4);
  assign wr_ctrl = wr_i && (addr_i == `CPIU_OFS_CTRL);

  // The summary is pure logic, so it can never disagree with the
  // individual change flags and software cannot write it.
  assign chg_sum = |chg_flag;

  // Without a valid history the first sample after reset could
  // look like an edge; pin_seen suppresses that false event.
  assign pin_edge = pin_seen &&
                    (edge_sel ? (ext_pin_i && !pin_prev)
                              : (!ext_pin_i && pin_prev));

  // Each flag is ANDed with its own enable; group terms also need
  // the peripheral group enable; the change flags share one enable through their summary.
  assign any_en =
      (ctrl[`CPIU_CTL_TMR_FLG] && ctrl[`CPIU_CTL_TMR_EN]) ||
      (ctrl[`CPIU_CTL_EXT_FLG] && ctrl[`CPIU_CTL_EXT_EN]) ||
      (chg_sum && ctrl[`CPIU_CTL_CHG_EN]) ||
      (ctrl[`CPIU_CTL_PERIPHERAL_IRQ_ENABLE] &&
       (|(pflag[0] & pen[0]) || |(pflag[1] & pen[1])));

  // Requests are judged only at the opening of an instruction
  // cycle, so the length of the running instruction is ignored.
  assign take = is_q1 && (state == ST_IDLE) && irq_req_o &&
                !sleep_i && (hold == 2'h0);

  // ---------------------------------------------------------------
  // Phase counter
  // ---------------------------------------------------------------
  // Four clock edges make one instruction cycle.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o <= `CPIU_PHASE_Q1;
    end else begin
      phase_o <= phase_o + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Control register and top-level flags
  // ---------------------------------------------------------------
  // An event in the same cycle as a software clear keeps its flag.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `CPIU_RST_BYTE;
    end else begin
      if (take) begin
        ctrl[`CPIU_CTL_GIE] <= 1'b0;
      end else if (return_from_isr_instr_i) begin
        ctrl[`CPIU_CTL_GIE] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl[`CPIU_CTL_GIE] <= wdata_i[`CPIU_CTL_GIE];
      end
      if (wr_ctrl) begin
        ctrl[6:3] <= wdata_i[6:3];
      end
      ctrl[`CPIU_CTL_TMR_FLG] <= tmr_evt_i ||
        (wr_ctrl ? wdata_i[`CPIU_CTL_TMR_FLG]
                 : ctrl[`CPIU_CTL_TMR_FLG]);
      // The pin flag may set on any edge, Q4 and Q1 included.
      ctrl[`CPIU_CTL_EXT_FLG] <= pin_edge ||
        (wr_ctrl ? wdata_i[`CPIU_CTL_EXT_FLG]
                 : ctrl[`CPIU_CTL_EXT_FLG]);
      // Bit 0 is never stored; it reads back as the summary.
      ctrl[`CPIU_CTL_CHG_FLG] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral flag and enable registers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_grp
      wire wr_flag;                     // Write to this flag register.
      wire wr_en;                       // Write to this enable register.
      assign wr_flag = wr_i && (addr_i == (g == 0 ? `CPIU_OFS_FLAG_A
                                                  : `CPIU_OFS_FLAG_B));
      assign wr_en   = wr_i && (addr_i == (g == 0 ? `CPIU_OFS_EN_A
                                                  : `CPIU_OFS_EN_B));
      // Flags set on their events whatever the enables hold.
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pflag[g] <= `CPIU_RST_BYTE;
          pen[g]   <= `CPIU_RST_BYTE;
        end else begin
          pflag[g] <= evt[g] | (wr_flag ? wdata_i : pflag[g]);
          if (wr_en) begin
            pen[g] <= wdata_i;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin edge logic and change flags
  // ---------------------------------------------------------------
  // Pin history, edge select and the change flag register.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_prev <= 1'b0;
      pin_seen <= 1'b0;
      edge_sel <= 1'b0;
      chg_flag <= `CPIU_RST_BYTE;
    end else begin
      pin_prev <= ext_pin_i;
      pin_seen <= 1'b1;
      if (wr_i && (addr_i == `CPIU_OFS_EDGE)) begin
        edge_sel <= wdata_i[`CPIU_EDGE_SEL];
      end
      chg_flag <= chg_evt_i |
        ((wr_i && (addr_i == `CPIU_OFS_PCF)) ? wdata_i : chg_flag);
    end
  end

  // ---------------------------------------------------------------
  // Request, wake and entry sequencer
  // ---------------------------------------------------------------
  // Entry takes two forced no-op cycles, so the vector runs three
  // cycles after the sampling edge; an event arriving after that
  // edge waits up to one more cycle for the next sample.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ST_IDLE;
      hold      <= 2'h0;
      irq_req_o <= 1'b0;
      flush_o   <= 1'b0;
      push_o    <= 1'b0;
      push_pc_o <= {PC_W{1'b0}};
      pc_load_o <= 1'b0;
      pc_val_o  <= {PC_W{1'b0}};
      pop_o     <= 1'b0;
      restore_o <= 1'b0;
      wake_o    <= 1'b0;
    end else begin
      irq_req_o <= ctrl[`CPIU_CTL_GIE] && any_en;
      flush_o   <= 1'b0;
      push_o    <= 1'b0;
      pc_load_o <= 1'b0;
      pop_o     <= return_from_isr_instr_i;
      restore_o <= return_from_isr_instr_i;
      // Wake needs only the source and group enables; the global enable then
      // decides whether the wake vectors or simply continues.
      wake_o    <= sleep_i && any_en;
      if (sleep_i && any_en) begin
        hold <= `CPIU_WAKE_HOLD;
      end else if (is_q1 && !sleep_i && (hold != 2'h0)) begin
        hold <= hold - 2'h1;
      end
      case (state)
        ST_IDLE: begin
          if (take) begin
            flush_o   <= 1'b1;
            push_o    <= 1'b1;
            push_pc_o <= pc_i;
            state     <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (is_q1) begin
            pc_load_o <= 1'b1;
            pc_val_o  <= `CPIU_VECTOR;
            state     <= ST_VEC;
          end
        end
        ST_VEC: begin
          // The vector fetch completes in this cycle.
          if (is_q1) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shadow context registers
  // ---------------------------------------------------------------
  // Hardware capture on entry wins over a software write in the same
  // edge; a capture is the only consistent snapshot of the context.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shd_acc_o  <= `CPIU_RST_BYTE;
      shd_stat_o <= `CPIU_RST_BYTE;
      shd_bsr_o  <= 5'h00;
      shd_fsr0_o <= 16'h0000;
      shd_fsr1_o <= 16'h0000;
      shd_pclh_o <= 7'h00;
    end else if (take) begin
      shd_acc_o  <= live_acc_i;
      shd_stat_o <= live_stat_i & `CPIU_STAT_KEEP;
      shd_bsr_o  <= live_bsr_i;
      shd_fsr0_o <= live_fsr0_i;
      shd_fsr1_o <= live_fsr1_i;
      shd_pclh_o <= live_pclh_i;
    end else if (wr_i) begin
      // Edits here are what the return puts back.
      case (addr_i)
        `CPIU_OFS_SHD_ACC:  shd_acc_o <= wdata_i;
        `CPIU_OFS_SHD_STAT: shd_stat_o <= wdata_i & `CPIU_STAT_KEEP;
        `CPIU_OFS_SHD_BSR:  shd_bsr_o <= wdata_i[4:0];
        `CPIU_OFS_SHD_PCLH: shd_pclh_o <= wdata_i[6:0];
        `CPIU_OFS_SHD_F0L:  shd_fsr0_o[7:0] <= wdata_i;
        `CPIU_OFS_SHD_F0H:  shd_fsr0_o[15:8] <= wdata_i;
        `CPIU_OFS_SHD_F1L:  shd_fsr1_o[7:0] <= wdata_i;
        `CPIU_OFS_SHD_F1H:  shd_fsr1_o[15:8] <= wdata_i;
        default: begin
          shd_acc_o <= shd_acc_o;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Data stands only in the cycle after the strobe; unmapped reads
  // and idle cycles show zero.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `CPIU_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `CPIU_OFS_CTRL:     rdata_o <= {ctrl[7:1], chg_sum};
        `CPIU_OFS_FLAG_A:   rdata_o <= pflag[0];
        `CPIU_OFS_FLAG_B:   rdata_o <= pflag[1];
        `CPIU_OFS_EN_A:     rdata_o <= pen[0];
        `CPIU_OFS_EN_B:     rdata_o <= pen[1];
        `CPIU_OFS_EDGE:     rdata_o <= {7'h00, edge_sel};
        `CPIU_OFS_PCF:      rdata_o <= chg_flag;
        `CPIU_OFS_SHD_ACC:  rdata_o <= shd_acc_o;
        `CPIU_OFS_SHD_STAT: rdata_o <= shd_stat_o;
        `CPIU_OFS_SHD_BSR:  rdata_o <= {3'h0, shd_bsr_o};
        `CPIU_OFS_SHD_PCLH: rdata_o <= {1'b0, shd_pclh_o};
        `CPIU_OFS_SHD_F0L:  rdata_o <= shd_fsr0_o[7:0];
        `CPIU_OFS_SHD_F0H:  rdata_o <= shd_fsr0_o[15:8];
        `CPIU_OFS_SHD_F1L:  rdata_o <= shd_fsr1_o[7:0];
        `CPIU_OFS_SHD_F1H:  rdata_o <= shd_fsr1_o[15:8];
        default:            rdata_o <= `CPIU_RST_BYTE;
      endcase
    end else begin
      rdata_o <= `CPIU_RST_BYTE;
    end
  end

endmodule // cpiu_irq_unit

// ===== verif/cpiu_irq_props.sv
// Concurrent checks on the ports of the interrupt unit.
`include "cpiu_defines.vh"

module cpiu_irq_props #(
  parameter PC_W = 15                   // Program counter width.
) (
  input logic            clk_i,       // Clock.
  input logic            rst_n_i,     // Reset, active low.
  input logic            rd_i,        // Read strobe.
  input logic            return_from_isr_instr_i,    // Return pulse.
  input logic            sleep_i,     // Core asleep.
  input logic [PC_W-1:0] pc_i,        // Program counter.
  input logic [7:0]      live_acc_i,  // Live accumulator.
  input logic [7:0]      rdata_o,     // Read data.
  input logic [1:0]      phase_o,     // Phase.
  input logic            irq_req_o,   // Request.
  input logic            flush_o,     // Flush pulse.
  input logic            push_o,      // Push pulse.
  input logic [PC_W-1:0] push_pc_o,   // Pushed address.
  input logic            pc_load_o,   // Vector load.
  input logic [PC_W-1:0] pc_val_o,    // Vector value.
  input logic            pop_o,       // Pop pulse.
  input logic            restore_o,   // Restore pulse.
  input logic [7:0]      shd_acc_o,   // Shadow accumulator.
  input logic [7:0]      shd_stat_o   // Shadow status.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Port relations on the instruction clock.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_entry_pair:
    assert property (flush_o |-> push_o && phase_o == 2'h0)
    else $error("entry pulses not paired at Q1");
  chk_entry_cause:
    assert property (flush_o |-> $past(irq_req_o) && !$past(sleep_i))
    else $error("entry without request or while asleep");
  chk_vector_load:
    assert property (flush_o |-> ##4 (pc_load_o && pc_val_o == `CPIU_VECTOR))
    else $error("vector not loaded four clocks after entry");
  chk_load_cause:
    assert property (pc_load_o |-> $past(flush_o, 4))
    else $error("vector load without entry");
  chk_push_value:
    assert property (flush_o |-> push_pc_o == $past(pc_i))
    else $error("pushed address wrong");
  chk_shadow_save:
    assert property (flush_o |-> shd_acc_o == $past(live_acc_i)
                     && shd_stat_o[4:3] == 2'b00)
    else $error("context not saved on entry");
  chk_return_pair:
    assert property (return_from_isr_instr_i |=> pop_o && restore_o)
    else $error("return did not pop and restore");
  chk_pop_cause:
    assert property (pop_o |-> $past(return_from_isr_instr_i))
    else $error("pop without return");
  chk_single_entry:
    assert property (flush_o |=> !flush_o [*7])
    else $error("entry repeated too soon");
  chk_rdata_idle:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule // cpiu_irq_props

bind cpiu_irq_unit cpiu_irq_props #(.PC_W(PC_W)) i_cpiu_irq_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i), .return_from_isr_instr_i(return_from_isr_instr_i),
  .sleep_i(sleep_i), .pc_i(pc_i), .live_acc_i(live_acc_i),
  .rdata_o(rdata_o), .phase_o(phase_o), .irq_req_o(irq_req_o),
  .flush_o(flush_o), .push_o(push_o), .push_pc_o(push_pc_o),
  .pc_load_o(pc_load_o), .pc_val_o(pc_val_o), .pop_o(pop_o),
  .restore_o(restore_o), .shd_acc_o(shd_acc_o), .shd_stat_o(shd_stat_o));

// ===== verif/cpiu_core_model.sv
// Core sequencer model: program counter, return stack, live context.
module cpiu_core_model (
  input  logic        clk_i,       // Clock.
  input  logic        rst_n_i,     // Reset, active low.
  input  logic [1:0]  phase_i,     // Phase from the unit.
  input  logic        push_i,      // Push request.
  input  logic [14:0] push_pc_i,   // Address to push.
  input  logic        pc_load_i,   // Vector load.
  input  logic [14:0] pc_val_i,    // Vector value.
  input  logic        pop_i,       // Pop request.
  input  logic        restore_i,   // Restore request.
  input  logic [7:0]  shd_acc_i,   // Shadow accumulator.
  input  logic [7:0]  shd_stat_i,  // Shadow status.
  input  logic [4:0]  shd_bsr_i,   // Shadow bank select.
  output logic [14:0] pc_o,        // Program counter.
  output logic [7:0]  acc_o,       // Live accumulator.
  output logic [7:0]  stat_o,      // Live status.
  output logic [4:0]  bsr_o        // Live bank select.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] stk [0:15];         // Return stack.
  logic [3:0]  sp;                 // Stack pointer.

  // ------------------------------------------------------------
  // Sequencer: live accumulator and bank select churn each cycle, so
  // a lost restore would show as a wrong value.
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o   <= 15'h0000;
      sp     <= 4'h0;
      acc_o  <= 8'h00;
      stat_o <= 8'h18;             // Watchdog and sleep bits set.
      bsr_o  <= 5'h00;
    end else begin
      if (push_i) begin
        stk[sp] <= push_pc_i;
        sp <= sp + 4'h1;
      end
      if (pc_load_i) begin
        pc_o <= pc_val_i;
      end else if (pop_i) begin
        pc_o <= stk[sp - 4'h1];
        sp <= sp - 4'h1;
      end else if (phase_i == 2'h3) begin
        pc_o <= pc_o + 15'h0001;
      end
      if (restore_i) begin
        acc_o  <= shd_acc_i;
        bsr_o  <= shd_bsr_i;
        stat_o <= {shd_stat_i[7:5], stat_o[4:3], shd_stat_i[2:0]};
      end else if (phase_i == 2'h3) begin
        acc_o <= acc_o + 8'h11;
        bsr_o <= bsr_o + 5'h01;
      end
    end
  end
endmodule // cpiu_core_model

// ===== verif/tb_top.sv
// Self-checking bench for the interrupt unit with a core model.
`include "cpiu_defines.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd, tmr, pin, return_from_isr_instr, sleep; // Drives.
  logic [11:0] addr;                    // Register address.
  logic [7:0]  wdata, evt_a, chg;       // Data and events.
  logic [7:0]  rdata, acc, stat, s_acc, s_stat; // Observed values.
  logic [4:0]  bank_select_reg, s_bsr;              // Bank select, live and shadow.
  logic [14:0] pc, push_pc, pc_val;     // Addresses.
  logic [1:0]  phase;                   // Phase.
  logic        irq, flush, push, load, pop, rest, wake; // Controls.
  int          miscompares, tests_run, n_flush, k; // Counters.

  always #4 clk = ~clk;                 // 125 MHz.
  always @(posedge flush) n_flush++;

  cpiu_irq_unit i_cpiu_irq_unit (.clk_i(clk), .rst_n_i(rst_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .tmr_evt_i(tmr), .evt_a_i(evt_a),
    .evt_b_i(8'h00), .chg_evt_i(chg), .ext_pin_i(pin), .pc_i(pc),
    .live_acc_i(acc), .live_stat_i(stat), .live_bsr_i(bank_select_reg),
    .live_fsr0_i(16'h1234), .live_fsr1_i(16'h5678),
    .live_pclh_i(7'h15), .return_from_isr_instr_i(return_from_isr_instr), .sleep_i(sleep),
    .phase_o(phase), .irq_req_o(irq), .flush_o(flush), .push_o(push),
    .push_pc_o(push_pc), .pc_load_o(load), .pc_val_o(pc_val),
    .pop_o(pop), .restore_o(rest), .wake_o(wake), .shd_acc_o(s_acc),
    .shd_stat_o(s_stat), .shd_bsr_o(s_bsr), .shd_fsr0_o(),
    .shd_fsr1_o(), .shd_pclh_o());
  cpiu_core_model i_cpiu_core_model (.clk_i(clk), .rst_n_i(rst_n),
    .phase_i(phase), .push_i(push), .push_pc_i(push_pc),
    .pc_load_i(load), .pc_val_i(pc_val), .pop_i(pop),
    .restore_i(rest), .shd_acc_i(s_acc), .shd_stat_i(s_stat),
    .shd_bsr_i(s_bsr), .pc_o(pc), .acc_o(acc), .stat_o(stat),
    .bsr_o(bank_select_reg));

  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    #1;
    chk("idle data", {8'h00, rdata}, 16'h0000);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", {8'h00, rdata}, {8'h00, e});
  endtask
  // Bounded wait: 0 entry, 1 vector load, 2 wake.
  task automatic wait_on(input int sel, output int n);
    n = 0;
    while (!(sel == 0 ? flush === 1'b1 :
             sel == 1 ? load === 1'b1 : wake === 1'b1)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 40) begin
        miscompares++;
        end_of_test();
      end
    end
  endtask
  task automatic pulse_return_from_isr_instr();
    @(posedge clk);
    return_from_isr_instr <= 1'b1;
    @(posedge clk);
    return_from_isr_instr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    {clk, rst_n, wr, rd, tmr, pin, return_from_isr_instr, sleep} = 8'h00;
    {addr, wdata, evt_a, chg} = 36'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`CPIU_OFS_CTRL, 8'h00);
    rd_chk(`CPIU_OFS_EN_A, 8'h00);
    rd_chk(`CPIU_OFS_SHD_ACC, 8'h00);
    rd_chk(12'h123, 8'h00);
    // A disabled timer event only records its flag.
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
    rd_chk(`CPIU_OFS_CTRL, 8'h04);
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    rd_chk(`CPIU_OFS_CTRL, 8'h00);
    // The change summary follows the port flags, not writes.
    @(posedge clk) chg <= 8'h04;
    @(posedge clk) chg <= 8'h00;
    rd_chk(`CPIU_OFS_PCF, 8'h04);
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    rd_chk(`CPIU_OFS_CTRL, 8'h01);
    wr_reg(`CPIU_OFS_PCF, 8'h00);
    rd_chk(`CPIU_OFS_CTRL, 8'h00);
    // Group source waits for the group enable, then is serviced.
    @(posedge clk) evt_a <= 8'h08;
    @(posedge clk) evt_a <= 8'h00;
    wr_reg(`CPIU_OFS_EN_A, 8'h08);
    wr_reg(`CPIU_OFS_CTRL, 8'h80);
    repeat (8) @(posedge clk);
    chk("request", irq, 1'b0);
    wr_reg(`CPIU_OFS_CTRL, 8'hC0);
    wait_on(0, k);
    chk("entries", n_flush, 1);
    wait_on(1, k);
    rd_chk(`CPIU_OFS_CTRL, 8'h40);
    wr_reg(`CPIU_OFS_SHD_ACC, 8'hA5);
    rd_chk(`CPIU_OFS_SHD_ACC, 8'hA5);
    wr_reg(`CPIU_OFS_FLAG_A, 8'h00);
    pulse_return_from_isr_instr();
    chk("restored acc", acc, 8'hA5);
    chk("kept status", stat[4:3], 2'h3);
    rd_chk(`CPIU_OFS_CTRL, 8'hC0);
    chk("entries", n_flush, 1);
    // A flag left set re-enters after the return.
    @(posedge clk) evt_a <= 8'h08;
    @(posedge clk) evt_a <= 8'h00;
    wait_on(0, k);
    pulse_return_from_isr_instr();
    wait_on(0, k);
    chk("entries", n_flush, 3);
    wr_reg(`CPIU_OFS_FLAG_A, 8'h00);
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    pulse_return_from_isr_instr();
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    // Pin edges: falling by default, rising once selected.
    @(posedge clk) pin <= 1'b1;
    rd_chk(`CPIU_OFS_CTRL, 8'h00);
    @(posedge clk) pin <= 1'b0;
    rd_chk(`CPIU_OFS_CTRL, 8'h02);
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    wr_reg(`CPIU_OFS_EDGE, 8'h01);
    wr_reg(`CPIU_OFS_CTRL, 8'h90);
    @(posedge clk) pin <= 1'b1;
    wait_on(1, k);
    chk("latency", (k >= 4 && k <= 20), 1'b1);
    chk("vector", pc_val, `CPIU_VECTOR);
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    pulse_return_from_isr_instr();
    wr_reg(`CPIU_OFS_CTRL, 8'h00);
    // Wake with the global enable clear continues without entry.
    wr_reg(`CPIU_OFS_CTRL, 8'h20);
    sleep <= 1'b1;
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
    wait_on(2, k);
    sleep <= 1'b0;
    repeat (12) @(posedge clk);
    chk("entries", n_flush, 4);
    end_of_test();
  end
endmodule // tb_top
